// ---- verilog/ffop_top.sv ----
// Flag and offset programming logic of a deep FIFO, with its data buffer
`timescale 1ns/1ps
`default_nettype none

// ************************************************************************
// Data buffer
// ************************************************************************
module ffop_buf #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] fill_r;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	assign in_ready = (fill_r != (AW+1)'(DEPTH));
	assign out_valid = (fill_r != '0);
	assign out_data = mem[rd_ptr_r];

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			fill_r <= '0;
		end else begin
			wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
			rd_ptr_r <= pop ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
			fill_r <= (AW+1)'(fill_r + (AW+1)'(push) - (AW+1)'(pop));
		end
	end
endmodule : ffop_buf

// ************************************************************************
// Flag and offset logic
// ************************************************************************
// Contract
// R1 - Parallel-method master reset picks default offsets 16383, 8191, 4095 or 127.
// R2 - Serial-method master reset picks default offsets 2047, 1023, 511 or 255.
// R3 - Load method is caught at master reset; high serial, low parallel.
// R4 - Offsets read back only on the parallel output port, never serially.
// R5 - Offsets may be reprogrammed anytime after reset; values 0 to depth minus one.
// R6 - Synchronous timing: almost-full moves on write edges, almost-empty on read edges.
// R7 - Asynchronous timing: each almost flag asserts on one clock, clears on the other.
// R8 - Standard mode thresholds for empty, almost-empty, half, almost-full and full flags.
// R9 - First-word mode thresholds shifted by one word, with ready flags.
// R10 - Parallel writes fill offset halves in turn: empty LSB, MSB, full LSB, MSB.
// R11 - Parallel reads drive offset halves in turn onto the outputs.
// R12 - Serial shift of 34 bits, empty LSB first, full MSB last.
// R13 - Offsets hold 17 bits; unused bits of written halves are ignored.
// R14 - Programming and readback behave the same in both timing modes.
// R15 - First-word mode is caught at master reset from the first-word pin.
// R16 - With load select high, write and read enables access FIFO memory.
// R17 - Master reset puts both offset pointers at the empty LSB register.
// R18 - Offset pointers wrap from the full MSB back to the empty LSB.
module ffop_top (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Control pins from the write and read controllers
	input wire logic master_reset_n,
	input wire logic write_clock,
	input wire logic read_clock,
	input wire logic load_select,
	input wire logic write_enable_n,
	input wire logic read_enable_n,
	input wire logic serial_enable_n,
	input wire logic first_word_serial_in,
	input wire logic offset_select_1,
	input wire logic offset_select_0,
	input wire logic flag_timing_select,
	input wire logic [ffop_pkg::DATA_W-1:0] data_in,
	// Parallel output port
	output logic [ffop_pkg::DATA_W-1:0] data_out,
	// Status flags, levels as on the pins
	output logic empty_flag,
	output logic full_flag,
	output logic output_ready,
	output logic input_ready,
	output logic almost_empty_flag,
	output logic almost_full_flag,
	output logic half_full_flag,
	// Memory side
	output logic mem_wr_valid,
	input wire logic mem_wr_ready,
	output logic [ffop_pkg::DATA_W-1:0] mem_wr_data,
	output logic mem_rd_pulse
);
	localparam int PIN_W = 11 + ffop_pkg::DATA_W;
	localparam int OW = ffop_pkg::OFS_W;
	localparam int CW = ffop_pkg::CNT_W;

	// ********************************************************************
	// Pin synchronisers
	// ********************************************************************
	// A change is taken only once stages two and three agree
	logic [PIN_W-1:0] pin_s1_r;
	logic [PIN_W-1:0] pin_s2_r;
	logic [PIN_W-1:0] pin_s3_r;
	logic [PIN_W-1:0] pin_f_r;
	logic wclk_d_r;
	logic rclk_d_r;
	wire [PIN_W-1:0] pin_raw = {write_clock, read_clock, master_reset_n, load_select,
		write_enable_n, read_enable_n, serial_enable_n, first_word_serial_in,
		offset_select_1, offset_select_0, flag_timing_select, data_in};
	wire [PIN_W-1:0] pin_f_nxt;
	wire p_wclk, p_rclk, p_mrs_n, p_ld, p_wen_n, p_ren_n, p_sen_n, p_si, p_fs1, p_fs0, p_pfm;
	wire [ffop_pkg::DATA_W-1:0] p_data;

	genvar gi;
	generate
		for (gi = 0; gi < PIN_W; gi++) begin : g_agree
			assign pin_f_nxt[gi] = (pin_s2_r[gi] == pin_s3_r[gi]) ? pin_s3_r[gi] : pin_f_r[gi];
		end
	endgenerate

	assign {p_wclk, p_rclk, p_mrs_n, p_ld, p_wen_n, p_ren_n, p_sen_n, p_si,
		p_fs1, p_fs0, p_pfm, p_data} = pin_f_r;

	always_ff @(posedge core_clk) begin
		pin_s1_r <= pin_raw;
		pin_s2_r <= pin_s1_r;
		pin_s3_r <= pin_s2_r;
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			pin_f_r <= '0;
			wclk_d_r <= 1'b0;
			rclk_d_r <= 1'b0;
		end else begin
			pin_f_r <= pin_f_nxt;
			wclk_d_r <= p_wclk;
			rclk_d_r <= p_rclk;
		end
	end

	wire wr_edge = p_wclk && !wclk_d_r;
	wire rd_edge = p_rclk && !rclk_d_r;
	wire in_mrs = !p_mrs_n;

	// ********************************************************************
	// Configuration caught at master reset
	// ********************************************************************
	logic serial_mode_r;
	logic first_word_mode_mode_r;
	logic sync_flags_r;
	logic [2*OW-1:0] ofs_r;
	logic [2*OW-1:0] ofs_nxt;
	ffop_pkg::ffop_reg_t wptr_r;
	ffop_pkg::ffop_reg_t rptr_r;
	logic [OW-1:0] def_ofs;

	always_comb begin
		unique case ({p_ld, p_fs1, p_fs0})
			3'h2: def_ofs = ffop_pkg::DEF_16383; // R1
			3'h1: def_ofs = ffop_pkg::DEF_8191; // R1
			3'h3: def_ofs = ffop_pkg::DEF_4095; // R1
			3'h0: def_ofs = ffop_pkg::DEF_127; // R1
			3'h6: def_ofs = ffop_pkg::DEF_2047; // R2
			3'h4: def_ofs = ffop_pkg::DEF_1023; // R2
			3'h5: def_ofs = ffop_pkg::DEF_511; // R2
			3'h7: def_ofs = ffop_pkg::DEF_255; // R2
		endcase
	end

	wire [OW-1:0] empty_ofs = ofs_r[OW-1:0];
	wire [OW-1:0] full_ofs = ofs_r[2*OW-1:OW];

	// ********************************************************************
	// Offset programming and readback
	// ********************************************************************
	// Programming is decoded identically in both timing modes
	wire par_wr = wr_edge && !p_ld && !p_wen_n && p_ren_n && p_sen_n && !serial_mode_r; // R3 R10 R14
	wire ser_wr = wr_edge && !p_ld && p_wen_n && p_ren_n && !p_sen_n && serial_mode_r; // R3 R12 R14
	wire par_rd = rd_edge && !p_ld && p_wen_n && !p_ren_n && p_sen_n; // R4 R11 R14
	wire [ffop_pkg::LO_W-1:0] d_lo = p_data[ffop_pkg::LO_W-1:0];
	wire [ffop_pkg::HI_W-1:0] d_hi = p_data[ffop_pkg::HI_W-1:0];

	always_comb begin
		ofs_nxt = ofs_r;
		if (ser_wr) begin
			ofs_nxt = {p_si, ofs_r[2*OW-1:1]}; // R12
		end else if (par_wr) begin
			unique case (wptr_r)
				ffop_pkg::REG_EMPTY_LSB: ofs_nxt[ffop_pkg::LO_W-1:0] = d_lo; // R10 R13
				ffop_pkg::REG_EMPTY_MSB: ofs_nxt[OW-1:ffop_pkg::LO_W] = d_hi; // R10 R13
				ffop_pkg::REG_FULL_LSB: ofs_nxt[OW+ffop_pkg::LO_W-1:OW] = d_lo; // R10 R13
				ffop_pkg::REG_FULL_MSB: ofs_nxt[2*OW-1:OW+ffop_pkg::LO_W] = d_hi; // R10 R13
			endcase
		end
	end

	logic [ffop_pkg::DATA_W-1:0] rd_word;
	always_comb begin
		unique case (rptr_r)
			ffop_pkg::REG_EMPTY_LSB: rd_word = ffop_pkg::DATA_W'(empty_ofs[ffop_pkg::LO_W-1:0]);
			ffop_pkg::REG_EMPTY_MSB: rd_word = ffop_pkg::DATA_W'(empty_ofs[OW-1:ffop_pkg::LO_W]);
			ffop_pkg::REG_FULL_LSB: rd_word = ffop_pkg::DATA_W'(full_ofs[ffop_pkg::LO_W-1:0]);
			ffop_pkg::REG_FULL_MSB: rd_word = ffop_pkg::DATA_W'(full_ofs[OW-1:ffop_pkg::LO_W]);
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			serial_mode_r <= 1'b0;
			first_word_mode_mode_r <= 1'b0;
			sync_flags_r <= 1'b0;
			ofs_r <= {ffop_pkg::DEF_127, ffop_pkg::DEF_127};
			wptr_r <= ffop_pkg::REG_EMPTY_LSB;
			rptr_r <= ffop_pkg::REG_EMPTY_LSB;
			data_out <= '0;
		end else if (in_mrs) begin
			serial_mode_r <= p_ld; // R3
			first_word_mode_mode_r <= p_si; // R15
			sync_flags_r <= p_pfm; // R6 R7
			ofs_r <= {def_ofs, def_ofs}; // R1 R2
			wptr_r <= ffop_pkg::REG_EMPTY_LSB; // R17
			rptr_r <= ffop_pkg::REG_EMPTY_LSB; // R17
		end else begin
			ofs_r <= ofs_nxt; // R5
			wptr_r <= par_wr ? ffop_pkg::ffop_reg_t'(wptr_r + 2'h1) : wptr_r; // R18
			rptr_r <= par_rd ? ffop_pkg::ffop_reg_t'(rptr_r + 2'h1) : rptr_r; // R18
			data_out <= par_rd ? rd_word : data_out; // R4 R11
		end
	end

	// ********************************************************************
	// Memory access and word count
	// ********************************************************************
	// Words wait in the buffer for the array; a full buffer refuses the write
	logic [CW-1:0] cnt_r;
	wire buf_in_ready;
	wire [CW-1:0] cap = first_word_mode_mode_r ? ffop_pkg::DEPTH_FIRST_WORD_MODE : ffop_pkg::DEPTH;
	wire mem_wr = wr_edge && p_ld && !p_wen_n && (cnt_r != cap) && buf_in_ready; // R16
	wire mem_rd = rd_edge && p_ld && !p_ren_n && (cnt_r != ffop_pkg::CNT_ZERO); // R16
	wire [CW-1:0] cnt_nxt = CW'(cnt_r + CW'(mem_wr) - CW'(mem_rd));

	ffop_buf #(
		.WIDTH(ffop_pkg::DATA_W),
		.DEPTH(ffop_pkg::BUF_DEPTH)
	) u_buf (
		.core_clk(core_clk),
		.sys_rst(sys_rst || in_mrs),
		.in_valid(mem_wr),
		.in_ready(buf_in_ready),
		.in_data(p_data),
		.out_valid(mem_wr_valid),
		.out_ready(mem_wr_ready),
		.out_data(mem_wr_data)
	);

	// ********************************************************************
	// Flag thresholds
	// ********************************************************************
	wire [CW-1:0] n_ext = CW'(empty_ofs);
	wire [CW-1:0] m_ext = CW'(full_ofs);
	wire [CW-1:0] ae_lim = first_word_mode_mode_r ? CW'(n_ext + ffop_pkg::CNT_ONE) : n_ext; // R8 R9
	wire [CW-1:0] af_lim = CW'(cap - m_ext); // R8 R9
	wire [CW-1:0] hf_lim = first_word_mode_mode_r ? ffop_pkg::HALF_FIRST_WORD_MODE : ffop_pkg::HALF_STD; // R8 R9
	wire ae_low = (cnt_nxt <= ae_lim);
	wire af_low = (cnt_nxt >= af_lim);
	wire is_empty = (cnt_nxt == ffop_pkg::CNT_ZERO);
	wire is_full = (cnt_nxt == cap);

	// Asynchronous timing: assert on one side, release only from the other
	wire af_sync_nxt = wr_edge ? !af_low : almost_full_flag; // R6
	wire af_async_nxt = (wr_edge && af_low) ? 1'b0 :
		((rd_edge && !af_low) ? 1'b1 : almost_full_flag); // R7
	wire ae_sync_nxt = rd_edge ? !ae_low : almost_empty_flag; // R6
	wire ae_async_nxt = (rd_edge && ae_low) ? 1'b0 :
		((wr_edge && !ae_low) ? 1'b1 : almost_empty_flag); // R7

	always_ff @(posedge core_clk) begin
		if (sys_rst || in_mrs) begin
			cnt_r <= ffop_pkg::CNT_ZERO;
			almost_empty_flag <= 1'b0;
			almost_full_flag <= 1'b1;
			half_full_flag <= 1'b1;
			empty_flag <= 1'b0;
			full_flag <= 1'b1;
			output_ready <= 1'b1;
			input_ready <= 1'b0;
			mem_rd_pulse <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			mem_rd_pulse <= mem_rd;
			almost_full_flag <= sync_flags_r ? af_sync_nxt : af_async_nxt; // R6 R7
			almost_empty_flag <= sync_flags_r ? ae_sync_nxt : ae_async_nxt; // R6 R7
			half_full_flag <= !(cnt_nxt >= hf_lim); // R8 R9
			empty_flag <= first_word_mode_mode_r ? 1'b1 : !is_empty; // R8
			full_flag <= first_word_mode_mode_r ? 1'b1 : !is_full; // R8
			output_ready <= first_word_mode_mode_r ? is_empty : 1'b1; // R9
			input_ready <= first_word_mode_mode_r ? is_full : 1'b0; // R9
		end
	end
endmodule : ffop_top

`default_nettype wire

// ---- verilog/ffop_pkg.sv ----
// Constants and types shared by the flag and offset programming logic
package ffop_pkg;
	// ********************************************************************
	// Widths
	// ********************************************************************
	localparam int DATA_W = 18;
	localparam int OFS_W = 17;
	localparam int LO_W = 9;
	localparam int HI_W = OFS_W - LO_W;
	localparam int CNT_W = 18;
	localparam int SYNC_STAGES = 3;
	localparam int BUF_DEPTH = 32;

	// ********************************************************************
	// Depth and flag thresholds
	// ********************************************************************
	localparam logic [CNT_W-1:0] DEPTH = 18'h20000;
	localparam logic [CNT_W-1:0] DEPTH_FIRST_WORD_MODE = 18'h20001;
	localparam logic [CNT_W-1:0] HALF_STD = 18'h10001;
	localparam logic [CNT_W-1:0] HALF_FIRST_WORD_MODE = 18'h10002;
	localparam logic [CNT_W-1:0] CNT_ZERO = 18'h00000;
	localparam logic [CNT_W-1:0] CNT_ONE = 18'h00001;

	// ********************************************************************
	// Default offsets chosen at master reset
	// ********************************************************************
	localparam logic [OFS_W-1:0] DEF_16383 = 17'h03fff;
	localparam logic [OFS_W-1:0] DEF_8191 = 17'h01fff;
	localparam logic [OFS_W-1:0] DEF_4095 = 17'h00fff;
	localparam logic [OFS_W-1:0] DEF_127 = 17'h0007f;
	localparam logic [OFS_W-1:0] DEF_2047 = 17'h007ff;
	localparam logic [OFS_W-1:0] DEF_1023 = 17'h003ff;
	localparam logic [OFS_W-1:0] DEF_511 = 17'h001ff;
	localparam logic [OFS_W-1:0] DEF_255 = 17'h000ff;

	// Offset register sequence, shared by write and read pointers
	typedef enum logic [1:0] {
		REG_EMPTY_LSB,
		REG_EMPTY_MSB,
		REG_FULL_LSB,
		REG_FULL_MSB
	} ffop_reg_t;
endpackage : ffop_pkg

// ---- verif/ffop_chk.sv ----
// Concurrent checks on the flag and offset logic ports
`timescale 1ns/1ps
`default_nettype none
module ffop_chk (
	// Clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// Controller pins
	input wire logic master_reset_n,
	input wire logic read_clock,
	// Outputs, and the memory write ready input
	input wire logic [ffop_pkg::DATA_W-1:0] data_out,
	input wire logic empty_flag,
	input wire logic full_flag,
	input wire logic output_ready,
	input wire logic input_ready,
	input wire logic almost_empty_flag,
	input wire logic almost_full_flag,
	input wire logic half_full_flag,
	input wire logic mem_wr_valid,
	input wire logic mem_wr_ready,
	input wire logic [ffop_pkg::DATA_W-1:0] mem_wr_data,
	input wire logic mem_rd_pulse
);
	// ********************************************************************
	// Ages of the last read clock rise and master reset
	// ********************************************************************
	logic [3:0] since_rd_r;
	logic [3:0] since_mr_r;
	logic read_clock_r;
	// Raw pins lead the synchronised view, so the bounds leave room
	always_ff @(posedge core_clk) begin
		read_clock_r <= read_clock;
		if (sys_rst || !master_reset_n || (read_clock && !read_clock_r))
			since_rd_r <= 4'h0;
		else if (since_rd_r != 4'hf)
			since_rd_r <= since_rd_r + 4'h1;
		if (sys_rst || !master_reset_n)
			since_mr_r <= 4'h0;
		else if (since_mr_r != 4'hf)
			since_mr_r <= since_mr_r + 4'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	a_rd_pulse_single: assert property (mem_rd_pulse |=> !mem_rd_pulse)
		else $error("read pulse too long");
	a_empty_full_excl: assert property (!(!empty_flag && !full_flag))
		else $error("empty and full together");
	a_empty_almost: assert property (!empty_flag |-> ##[0:2] !almost_empty_flag)
		else $error("empty without almost empty");
	a_full_almost: assert property (!full_flag |-> ##[0:2] (!almost_full_flag && !half_full_flag))
		else $error("full without almost full");
	a_ready_excl: assert property (!(input_ready && output_ready))
		else $error("both ready flags high");
	a_rst_values: assert property ($fell(sys_rst) |-> !empty_flag && full_flag && !mem_wr_valid)
		else $error("bad values after reset");
	a_wr_hold_stall: assert property (since_mr_r > 4'h9 && mem_wr_valid && !mem_wr_ready
		|=> mem_wr_valid && $stable(mem_wr_data))
		else $error("memory word dropped while stalled");
	a_out_after_read: assert property ($changed(data_out) |-> since_rd_r <= 4'ha)
		else $error("readback word changed without read clock");
	a_pulse_after_read: assert property (mem_rd_pulse |-> since_rd_r <= 4'ha)
		else $error("read pulse without read clock");
endmodule : ffop_chk
bind ffop_top ffop_chk u_ffop_chk (.core_clk, .sys_rst, .master_reset_n, .read_clock, .data_out,
	.empty_flag, .full_flag, .output_ready, .input_ready, .almost_empty_flag, .almost_full_flag,
	.half_full_flag, .mem_wr_valid, .mem_wr_ready, .mem_wr_data, .mem_rd_pulse);
`default_nettype wire

// ---- verif/ffop_host.sv ----
// Write and read controller model driving the device pins
`timescale 1ns/1ps
`default_nettype none
module ffop_host (
	// Clock
	input wire logic core_clk,
	// Pins toward the device
	output logic master_reset_n,
	output logic write_clock,
	output logic read_clock,
	output logic load_select,
	output logic write_enable_n,
	output logic read_enable_n,
	output logic serial_enable_n,
	output logic first_word_serial_in,
	output logic offset_select_1,
	output logic offset_select_0,
	output logic flag_timing_select,
	output logic [ffop_pkg::DATA_W-1:0] data_in
);
	// ********************************************************************
	// Pin sequencing
	// ********************************************************************
	int slack = 0;
	event rd_done;
	initial begin
		master_reset_n = 1'b1;
		{write_clock, read_clock, load_select, first_word_serial_in} = 4'h0;
		{write_enable_n, read_enable_n, serial_enable_n} = 3'h7;
		{offset_select_1, offset_select_0, flag_timing_select} = 3'h0;
		data_in = '0;
	end
	task automatic mreset(input logic [4:0] cfg);
		@(negedge core_clk);
		{load_select, offset_select_1, offset_select_0, flag_timing_select, first_word_serial_in} = cfg;
		master_reset_n = 1'b0;
		repeat (12) @(negedge core_clk);
		master_reset_n = 1'b1;
		repeat (10) @(negedge core_clk);
		first_word_serial_in = ~cfg[0];
	endtask : mreset
	// Qualifiers flip once their hold is over, so stale values never pass
	task automatic pulse(input logic wr, input logic [3:0] ctl, input logic si,
		input logic [ffop_pkg::DATA_W-1:0] d);
		@(negedge core_clk);
		{load_select, write_enable_n, read_enable_n, serial_enable_n} = ctl;
		first_word_serial_in = si;
		data_in = d;
		repeat (5 + slack) @(negedge core_clk);
		write_clock = wr;
		read_clock = !wr;
		repeat (6) @(negedge core_clk);
		{write_clock, read_clock} = 2'h0;
		repeat (5) @(negedge core_clk);
		if (!wr && ctl == 4'h5)
			->rd_done;
		{write_enable_n, read_enable_n, serial_enable_n} = 3'h7;
		first_word_serial_in = !si;
		data_in = ~d;
	endtask : pulse
	task automatic pwrite(input logic [ffop_pkg::DATA_W-1:0] d);
		pulse(1'b1, 4'h3, 1'b0, d);
	endtask : pwrite
	task automatic pread();
		pulse(1'b0, 4'h5, 1'b0, 18'h00000);
	endtask : pread
	task automatic sbit(input logic b);
		pulse(1'b1, 4'h6, b, 18'h00000);
	endtask : sbit
	task automatic mwrite(input logic [ffop_pkg::DATA_W-1:0] d);
		pulse(1'b1, 4'hb, 1'b0, d);
	endtask : mwrite
	task automatic mread();
		pulse(1'b0, 4'hd, 1'b0, 18'h00000);
	endtask : mread
endmodule : ffop_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the flag and offset logic
`timescale 1ns/1ps
`default_nettype none
`define CMP(a, e) begin samples_checked++; if ((a) !== (e)) begin err_total++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
	// ********************************************************************
	// Device, controllers and checks
	// ********************************************************************
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic mem_wr_ready = 1'b0;
	wire master_reset_n, write_clock, read_clock, load_select, write_enable_n, read_enable_n;
	wire serial_enable_n, first_word_serial_in, offset_select_1, offset_select_0;
	wire flag_timing_select, empty_flag, full_flag, output_ready, input_ready;
	wire almost_empty_flag, almost_full_flag, half_full_flag, mem_wr_valid, mem_rd_pulse;
	wire [ffop_pkg::DATA_W-1:0] data_in, data_out, mem_wr_data;
	int err_total = 0;
	int samples_checked = 0;
	logic [31:0] xs = 32'h00000021;
	logic [ffop_pkg::DATA_W-1:0] rq[$], mq[$], er_w, em_w;
	logic [16:0] dflt [8] = '{17'h0007f, 17'h01fff, 17'h03fff, 17'h00fff,
		17'h003ff, 17'h001ff, 17'h007ff, 17'h000ff};
	logic [33:0] sr;
	logic [ffop_pkg::DATA_W-1:0] v [5];
	always #5 core_clk = ~core_clk;
	ffop_top u_ffop_top (.core_clk, .sys_rst, .master_reset_n, .write_clock, .read_clock,
		.load_select, .write_enable_n, .read_enable_n, .serial_enable_n, .first_word_serial_in,
		.offset_select_1, .offset_select_0, .flag_timing_select, .data_in, .data_out, .empty_flag,
		.full_flag, .output_ready, .input_ready, .almost_empty_flag, .almost_full_flag,
		.half_full_flag, .mem_wr_valid, .mem_wr_ready, .mem_wr_data, .mem_rd_pulse);
	ffop_host u_ffop_host (.core_clk, .master_reset_n, .write_clock, .read_clock, .load_select,
		.write_enable_n, .read_enable_n, .serial_enable_n, .first_word_serial_in,
		.offset_select_1, .offset_select_0, .flag_timing_select, .data_in);
	function automatic logic [31:0] rnd();
		xs = xs ^ (xs << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
		return xs;
	endfunction : rnd
	task automatic read_back(input logic [16:0] e, input logic [16:0] f);
		rq.push_back({9'h000, e[8:0]});
		rq.push_back({10'h000, e[16:9]});
		rq.push_back({9'h000, f[8:0]});
		rq.push_back({10'h000, f[16:9]});
		repeat (4) u_ffop_host.pread();
	endtask : read_back
	task automatic close_out();
		$display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	always @(u_ffop_host.rd_done) begin
		er_w = rq.pop_front();
		`CMP(data_out, er_w)
	end
	always @(posedge core_clk) begin
		if (!sys_rst && mem_wr_valid === 1'b1 && mem_wr_ready) begin
			em_w = (mq.size() != 0) ? mq.pop_front() : ~mem_wr_data;
			`CMP(mem_wr_data, em_w)
		end
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		close_out();
	end
	initial begin
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			u_ffop_host.slack = int'(rnd() % 3);
			u_ffop_host.mreset({i[2:0], i[1], i[0]});
			`CMP(empty_flag, i[0]);
			`CMP(output_ready, 1'b1);
			`CMP(input_ready, 1'b0);
			`CMP(half_full_flag, 1'b1);
			read_back(dflt[i], dflt[i]);
		end
		u_ffop_host.mreset(5'h00);
		foreach (v[k]) begin
			v[k] = 18'(rnd());
			u_ffop_host.pwrite(v[k]);
		end
		read_back({v[1][7:0], v[4][8:0]}, {v[3][7:0], v[2][8:0]});
		rq.push_back({9'h000, v[4][8:0]});
		u_ffop_host.pread();
		u_ffop_host.mreset(5'h10);
		sr = 34'({rnd(), rnd()});
		for (int k = 0; k < 34; k++)
			u_ffop_host.sbit(sr[k]);
		u_ffop_host.pwrite(18'h3ffff);
		read_back(sr[16:0], sr[33:17]);
		mem_wr_ready = 1'b1;
		for (int t = 1; t >= 0; t--) begin
			u_ffop_host.mreset({3'h0, t[0], 1'b0});
			u_ffop_host.pwrite(18'h00001);
			u_ffop_host.pwrite(18'h00000);
			// Full offset 131069 puts the almost-full point at three words
			u_ffop_host.pwrite(18'h001fd);
			u_ffop_host.pwrite(18'h000ff);
			repeat (3) begin
				mq.push_back(18'(rnd()));
				u_ffop_host.mwrite(mq[$]);
			end
			`CMP(empty_flag, 1'b1);
			`CMP(almost_empty_flag, !t[0]);
			`CMP(almost_full_flag, 1'b0);
			u_ffop_host.mread();
			`CMP(almost_empty_flag, 1'b1);
			`CMP(almost_full_flag, !t[0]);
		end
		mem_wr_ready = 1'b0;
		u_ffop_host.mreset(5'h00);
		for (int k = 0; k < 33; k++) begin
			if (k < 32)
				mq.push_back(18'(rnd()));
			u_ffop_host.mwrite(k < 32 ? mq[$] : 18'h2aaaa);
		end
		`CMP(mem_wr_valid, 1'b1);
		// Random drain stalls make the buffer hold its head word under back-pressure
		for (int k = 0; k < 200 && mq.size() != 0; k++) begin
			mem_wr_ready = 1'(rnd());
			@(negedge core_clk);
		end
		mem_wr_ready = 1'b1;
		repeat (4) @(negedge core_clk);
		`CMP(mq.size(), 0);
		`CMP(mem_wr_valid, 1'b0);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
